// ---- rtl/drive_cfg.svh ----
`ifndef DRIVE_CFG_SVH
`define DRIVE_CFG_SVH

// register offsets
`define OFS_CTRL    8'h00
`define OFS_CHOP    8'h04
`define OFS_UDMAX   8'h08
`define OFS_MAINS   8'h0C
`define OFS_COEF    8'h10
`define OFS_ADJ     8'h14
`define OFS_TO_SIG  8'h18
`define OFS_TO_CH   8'h1C
`define OFS_TO_DIR  8'h20
`define OFS_STAT    8'h24
`define OFS_MASK    8'h28
`define OFS_LIVE    8'h2C
`define OFS_TEMP    8'h30

// control fields
`define CTRL_TMODE_LSB 0
`define CTRL_TMODE_MSB 2
`define CTRL_EMODE_LSB 4
`define CTRL_EMODE_MSB 5
`define CTRL_ON        8
`define CTRL_ACK       9

// reset values and limits, voltages in 0.1 V
`define CHOP_RST    16'h1D4C
`define CHOP_MAX    16'h2710
`define UDMAX_RST   16'h1F40
`define MAINS_RST   16'h1B58
`define COEF_RST    16'h0F3C
`define COEF_MAX    16'h7530
`define ADJ_RST     16'h0023
`define TO_RST      16'h03E8
`define TO_MAX      16'hFDE8
`define TEMP_FULL   32'h0000_00C8
`define RR_DIV      50'sh0F_4240

// fault codes shown on fault_code
`define CODE_F0706  16'h0706
`define CODE_F1430  16'h1430
`define CODE_F1431  16'h1431
`define CODE_F1432  16'h1432

// timing
`define TICK_MS_NS    1000000
`define CLK_PERIOD_NS 10

`endif

// ---- rtl/drive_encoder_chopper_monitor.sv ----
// Operation
// - chopper on only above trigger threshold
// - threshold above admissible voltage blocks chopper
// - threshold below mains peak at switch-on raises F0706
// - mode 1 maps analog input to 0..200 C
// - mode 0 off, mode 4 resistance measurement
// - mode 4 syncs on release plus start
// - rotor resistance scaled by temperature coefficient
// - encoder mode 0 off, mode 2 trips
// - supervision armed by release and start
// - trip needs uninterrupted full timeout
// - timeouts 0..65000 ms, zero disables
// - zero speed with reference gives F1430
// - faulty track sequence gives F1431
// - sign mismatch gives F1432
// - quarter turn toward reference resets direction check
//
// Implementation choices: the register offsets and the strobed register port.
`include "drive_cfg.svh"

module drive_encoder_chopper_monitor #(
	parameter int TICK_CYCLES    = `TICK_MS_NS / `CLK_PERIOD_NS,
	parameter int COUNTS_PER_REV = 1024,
	parameter int AIN_W          = 12
) (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic [7:0]               addr,
	input  wire logic [31:0]              wdata,
	input  wire logic                     wr_en,
	input  wire logic                     rd_en,
	output logic      [31:0]              rdata,
	input  wire logic [15:0]              dc_link_voltage,
	input  wire logic [AIN_W-1:0]         analog_multifunction_input,
	input  wire logic [15:0]              winding_temp_measured,
	input  wire logic [15:0]              rotor_resistance_base,
	input  wire logic signed [15:0]       speed_actual,
	input  wire logic signed [15:0]       speed_reference,
	input  wire logic                     drive_release,
	input  wire logic                     start_cw,
	input  wire logic                     start_ccw,
	input  wire logic                     enc_a,
	input  wire logic                     enc_b,
	output logic                          chopper_on,
	output logic      [15:0]              motor_temp,
	output logic      [15:0]              rotor_resistance,
	output logic                          fault_switch_off,
	output logic      [15:0]              fault_code,
	output logic                          irq
);
	localparam int AIN_MAX = (1 << AIN_W) - 1;
	localparam logic [15:0] QUARTER = 16'(COUNTS_PER_REV / 4);

	drive_pkg::temp_mode_type  temp_mode_q;
	drive_pkg::enc_mode_type   enc_mode_q;
	drive_pkg::boot_state_type boot_q;
	logic [15:0] chop_thr_q;
	logic [15:0] udmax_q;
	logic [15:0] mains_q;
	logic [15:0] coef_q;
	logic [15:0] adj_q;
	logic [15:0] timeout_q [3];
	logic [3:0]  stat_q;
	logic [3:0]  stat_d;
	logic [3:0]  mask_q;
	logic [4:0]  pin_meta_q;
	logic [4:0]  pin_q;
	logic [31:0] rdata_q;
	logic        chopper_on_q;
	logic [15:0] motor_temp_q;
	logic [15:0] rotor_res_q;
	logic        fso_q;
	logic [15:0] code_q;
	logic        irq_q;
	logic [31:0] tick_cnt_q;
	logic        tick_q;
	logic [15:0] moved_q;
	logic        quarter_q;
	logic        run_cmd;
	logic        enc_arm;
	logic        ack;
	logic        mains_err;
	logic        step;
	logic        fwd;
	logic        seq_err;
	logic        mismatch;
	logic [2:0]  cond;
	logic [2:0]  trip;
	logic [15:0] ain_temp;
	logic signed [16:0] dtemp;
	logic signed [49:0] rr_prod;
	logic signed [49:0] rr_new;

	assign rdata            = rdata_q;
	assign chopper_on       = chopper_on_q;
	assign motor_temp       = motor_temp_q;
	assign rotor_resistance = rotor_res_q;
	assign fault_switch_off = fso_q;
	assign fault_code       = code_q;
	assign irq              = irq_q;

	function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
		clamp16 = (v[31:16] != 16'h0000 || v[15:0] > lim) ? lim : v[15:0];
	endfunction

	// two flops on every pin before anything looks at it; left unreset so that the
	// tracks already show their real level when reset lifts and no false step follows
	always_ff @(posedge clk) begin
		pin_meta_q <= {enc_b, enc_a, start_ccw, start_cw, drive_release};
		pin_q      <= pin_meta_q;
	end

	assign run_cmd = pin_q[0] & (pin_q[1] | pin_q[2]);
	assign enc_arm = run_cmd && enc_mode_q == drive_pkg::ENC_ERROR
		&& boot_q == drive_pkg::BOOT_RUN;
	assign ack     = wr_en && addr == `OFS_CTRL && wdata[`CTRL_ACK];

	// parameter registers; chopper threshold, coefficient and timeouts clamped to their documented ranges
	always_ff @(posedge clk) begin
		if (reset) begin
			temp_mode_q <= drive_pkg::TEMP_OFF;
			enc_mode_q  <= drive_pkg::ENC_ERROR;
			chop_thr_q  <= `CHOP_RST;
			udmax_q     <= `UDMAX_RST;
			mains_q     <= `MAINS_RST;
			coef_q      <= `COEF_RST;
			adj_q       <= `ADJ_RST;
			mask_q      <= 4'h0;
			for (int i = 0; i < 3; i++)
				timeout_q[i] <= `TO_RST;
		end else if (wr_en) begin
			if (addr == `OFS_CTRL) begin
				temp_mode_q <= drive_pkg::temp_mode_type'(wdata[`CTRL_TMODE_MSB:`CTRL_TMODE_LSB]);
				enc_mode_q  <= drive_pkg::enc_mode_type'(wdata[`CTRL_EMODE_MSB:`CTRL_EMODE_LSB]);
			end else if (addr == `OFS_CHOP) begin
				chop_thr_q <= clamp16(wdata, `CHOP_MAX);
			end else if (addr == `OFS_UDMAX) begin
				udmax_q <= wdata[15:0];
			end else if (addr == `OFS_MAINS) begin
				mains_q <= wdata[15:0];
			end else if (addr == `OFS_COEF) begin
				coef_q <= clamp16(wdata, `COEF_MAX);
			end else if (addr == `OFS_ADJ) begin
				adj_q <= wdata[15:0];
			end else if (addr == `OFS_TO_SIG) begin
				timeout_q[0] <= clamp16(wdata, `TO_MAX);
			end else if (addr == `OFS_TO_CH) begin
				timeout_q[1] <= clamp16(wdata, `TO_MAX);
			end else if (addr == `OFS_TO_DIR) begin
				timeout_q[2] <= clamp16(wdata, `TO_MAX);
			end else if (addr == `OFS_MASK) begin
				mask_q <= wdata[3:0];
			end
		end
	end

	// switch-on: threshold is checked once when software turns the drive on
	always_ff @(posedge clk) begin
		if (reset) begin
			boot_q <= drive_pkg::BOOT_WAIT;
		end else begin
			case (boot_q)
				drive_pkg::BOOT_WAIT:
					if (wr_en && addr == `OFS_CTRL && wdata[`CTRL_ON])
						boot_q <= drive_pkg::BOOT_CHECK;
				drive_pkg::BOOT_CHECK: boot_q <= drive_pkg::BOOT_RUN;
				default: boot_q <= drive_pkg::BOOT_RUN;
			endcase
		end
	end

	assign mains_err = boot_q == drive_pkg::BOOT_CHECK && chop_thr_q < mains_q;

	// chopper: a threshold above the admissible voltage never fires
	always_ff @(posedge clk) begin
		if (reset)
			chopper_on_q <= 1'b0;
		else
			chopper_on_q <= chop_thr_q <= udmax_q && dc_link_voltage > chop_thr_q;
	end

	// millisecond tick shared by the three timers
	always_ff @(posedge clk) begin
		if (reset || tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q     <= !reset;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q     <= 1'b0;
		end
	end

	// temperature source selection and rotor resistance scaling
	always_comb begin
		ain_temp = 16'((32'(analog_multifunction_input) * `TEMP_FULL) / 32'(AIN_MAX));
		dtemp    = $signed({motor_temp_q[15], motor_temp_q}) - $signed({adj_q[15], adj_q});
		rr_prod  = 50'($signed({1'b0, rotor_resistance_base})) * 50'($signed({1'b0, coef_q}))
			* 50'(dtemp);
		rr_new   = 50'($signed({1'b0, rotor_resistance_base})) + rr_prod / `RR_DIV;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			motor_temp_q <= `ADJ_RST;
			rotor_res_q  <= 16'h0000;
		end else begin
			case (temp_mode_q)
				drive_pkg::TEMP_MFI: motor_temp_q <= ain_temp;
				drive_pkg::TEMP_START:
					if (run_cmd)
						motor_temp_q <= winding_temp_measured;
				default: motor_temp_q <= adj_q;
			endcase
			// negative result saturates; a huge one clips at full scale
			if (rr_new < 0)
				rotor_res_q <= 16'h0000;
			else if (rr_new > 50'sh0_FFFF)
				rotor_res_q <= 16'hFFFF;
			else
				rotor_res_q <= rr_new[15:0];
		end
	end

	quad_step u_quad (
		.clk       (clk),
		.reset     (reset),
		.trk_a     (pin_q[3]),
		.trk_b     (pin_q[4]),
		.step_q    (step),
		.fwd_q     (fwd),
		.seq_err_q (seq_err)
	);

	// zero actual speed has no sign and belongs to the signal check
	assign mismatch = (speed_reference > 0 && speed_actual < 0)
		|| (speed_reference < 0 && speed_actual > 0);

	// travel toward the reference is counted in fourfold steps
	always_ff @(posedge clk) begin
		if (reset || !mismatch || !enc_arm || quarter_q) begin
			moved_q   <= 16'h0000;
			quarter_q <= 1'b0;
		end else if (step && fwd == (speed_reference > 0)) begin
			moved_q   <= moved_q + 16'h0001;
			quarter_q <= moved_q + 16'h0001 >= QUARTER;
		end
	end

	assign cond[0] = speed_actual == 16'sh0000 && speed_reference != 16'sh0000;
	assign cond[1] = seq_err;
	assign cond[2] = mismatch && !quarter_q;

	timer_if tif [3] ();
	for (genvar g = 0; g < 3; g++) begin : g_tmr
		assign tif[g].cond    = cond[g];
		assign tif[g].arm     = enc_arm;
		assign tif[g].tick    = tick_q;
		assign tif[g].timeout = timeout_q[g];
		assign trip[g]        = tif[g].trip;
		fault_timer u_tmr (
			.clk   (clk),
			.reset (reset),
			.port  (tif[g])
		);
	end

	// first fault wins and holds until acknowledged; a fault in the ack cycle still lands
	always_ff @(posedge clk) begin
		if (reset) begin
			fso_q  <= 1'b0;
			code_q <= 16'h0000;
		end else if (!fso_q || ack) begin
			fso_q <= mains_err || (|trip);
			if (mains_err)
				code_q <= `CODE_F0706;
			else if (trip[0])
				code_q <= `CODE_F1430;
			else if (trip[1])
				code_q <= `CODE_F1431;
			else if (trip[2])
				code_q <= `CODE_F1432;
			else
				code_q <= 16'h0000;
		end
	end

	// sticky status: an event in the clearing read still lands
	assign stat_d = ((rd_en && addr == `OFS_STAT) ? 4'h0 : stat_q) | {trip, mains_err};

	always_ff @(posedge clk) begin
		if (reset) begin
			stat_q <= 4'h0;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q  <= |(stat_d & mask_q);
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset || !rd_en)
			rdata_q <= 32'h0000_0000;
		else if (addr == `OFS_CTRL)
			rdata_q <= {26'h000_0000, enc_mode_q, 1'b0, temp_mode_q};
		else if (addr == `OFS_CHOP)
			rdata_q <= {16'h0000, chop_thr_q};
		else if (addr == `OFS_UDMAX)
			rdata_q <= {16'h0000, udmax_q};
		else if (addr == `OFS_MAINS)
			rdata_q <= {16'h0000, mains_q};
		else if (addr == `OFS_COEF)
			rdata_q <= {16'h0000, coef_q};
		else if (addr == `OFS_ADJ)
			rdata_q <= {16'h0000, adj_q};
		else if (addr == `OFS_TO_SIG)
			rdata_q <= {16'h0000, timeout_q[0]};
		else if (addr == `OFS_TO_CH)
			rdata_q <= {16'h0000, timeout_q[1]};
		else if (addr == `OFS_TO_DIR)
			rdata_q <= {16'h0000, timeout_q[2]};
		else if (addr == `OFS_STAT)
			rdata_q <= {28'h000_0000, stat_q};
		else if (addr == `OFS_MASK)
			rdata_q <= {28'h000_0000, mask_q};
		else if (addr == `OFS_LIVE)
			rdata_q <= {24'h00_0000, boot_q, enc_arm, chopper_on_q, fso_q, trip};
		else if (addr == `OFS_TEMP)
			rdata_q <= {rotor_res_q, motor_temp_q};
		else
			rdata_q <= 32'h0000_0000;
	end

	a_chopper_gate: assert property (@(posedge clk) disable iff (reset)
		chopper_on_q |-> $past(dc_link_voltage > chop_thr_q))
		else $error("chopper on at or below threshold");
	a_chopper_block: assert property (@(posedge clk) disable iff (reset)
		$past(chop_thr_q > udmax_q) |-> !chopper_on_q)
		else $error("chopper on with threshold above limit");
	a_switch_on_err: assert property (@(posedge clk) disable iff (reset)
		(mains_err && !fso_q && !ack) |=> fso_q && code_q == `CODE_F0706)
		else $error("low threshold at switch-on not reported");
	a_mode_off_quiet: assert property (@(posedge clk) disable iff (reset)
		(enc_mode_q == drive_pkg::ENC_OFF)[*2] |-> trip == 3'h0)
		else $error("encoder fault with supervision off");
	a_arm_needs_run: assert property (@(posedge clk) disable iff (reset)
		!run_cmd |=> trip == 3'h0 || $past(trip != 3'h0, 2) == 1'b0 && !run_cmd ##0 trip == 3'h0)
		else $error("encoder fault while not released");
	a_signal_cause: assert property (@(posedge clk) disable iff (reset)
		$rose(trip[0]) |-> $past(speed_actual == 16'sh0000 && speed_reference != 16'sh0000))
		else $error("signal fault without zero speed");
	a_dir_cause: assert property (@(posedge clk) disable iff (reset)
		$rose(trip[2]) |-> $past(mismatch))
		else $error("direction fault without sign mismatch");
	a_quarter_reset: assert property (@(posedge clk) disable iff (reset)
		quarter_q |=> !trip[2] && moved_q == 16'h0000)
		else $error("quarter turn did not restart direction check");
endmodule

// ---- rtl/drive_pkg.sv ----
package drive_pkg;
	typedef enum logic [2:0] {
		TEMP_OFF   = 3'b000,
		TEMP_MFI   = 3'b001,
		TEMP_START = 3'b100
	} temp_mode_type;

	typedef enum logic [1:0] {
		ENC_OFF   = 2'b00,
		ENC_ERROR = 2'b10
	} enc_mode_type;

	typedef enum logic [1:0] {
		BOOT_WAIT  = 2'b00,
		BOOT_CHECK = 2'b01,
		BOOT_RUN   = 2'b10
	} boot_state_type;
endpackage

// ---- rtl/fault_timer.sv ----
module fault_timer (
	input wire logic clk,
	input wire logic reset,
	timer_if.timer   port
);
	logic [15:0] cnt_q;
	logic        live;
	logic        trip_q;

	// a zero timeout switches this check off
	assign live      = port.arm & port.cond & (port.timeout != 16'h0000);
	assign port.trip = trip_q;

	// any gap in the condition restarts the count
	always_ff @(posedge clk) begin
		if (reset || !live) begin
			cnt_q  <= 16'h0000;
			trip_q <= 1'b0;
		end else begin
			if (port.tick && cnt_q != port.timeout)
				cnt_q <= cnt_q + 16'h0001;
			trip_q <= (cnt_q == port.timeout);
		end
	end

	a_timer_restart: assert property (@(posedge clk) disable iff (reset)
		!(port.arm && port.cond) |=> cnt_q == 16'h0000 && !trip_q)
		else $error("timer kept counting through a gap");
	a_trip_at_limit: assert property (@(posedge clk) disable iff (reset)
		$rose(trip_q) |-> $past(cnt_q == port.timeout && port.timeout != 16'h0000))
		else $error("trip before the timeout was reached");
endmodule

// ---- rtl/quad_step.sv ----
module quad_step (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic trk_a,
	input  wire logic trk_b,
	output logic      step_q,
	output logic      fwd_q,
	output logic      seq_err_q
);
	logic [1:0] ab_q;
	logic [3:0] tr;

	assign tr = {ab_q, trk_b, trk_a};

	// fourfold decode; both tracks moving at once is an illegal step
	always_ff @(posedge clk) begin
		if (reset) begin
			ab_q      <= {trk_b, trk_a}; // track the idle level so release sees no jump
			step_q    <= 1'b0;
			fwd_q     <= 1'b0;
			seq_err_q <= 1'b0;
		end else begin
			ab_q   <= {trk_b, trk_a};
			step_q <= 1'b0;
			if (tr[3] != tr[1] && tr[2] != tr[0]) begin
				seq_err_q <= 1'b1;
			end else if (tr[3:2] != tr[1:0]) begin
				step_q    <= 1'b1;
				fwd_q     <= (tr == 4'h1) || (tr == 4'h7) || (tr == 4'hE) || (tr == 4'h8);
				seq_err_q <= 1'b0;
			end
		end
	end

	a_seq_error: assert property (@(posedge clk) disable iff (reset)
		(ab_q[1] != trk_b && ab_q[0] != trk_a) |=> seq_err_q && !step_q)
		else $error("illegal track sequence not flagged");
endmodule

// ---- rtl/timer_if.sv ----
interface timer_if;
	logic        cond;
	logic        arm;
	logic        tick;
	logic [15:0] timeout;
	logic        trip;
	modport ctrl  (output cond, arm, tick, timeout, input trip);
	modport timer (input cond, arm, tick, timeout, output trip);
endinterface

// ---- tb/drive_encoder_chopper_monitor_tb.sv ----
`include "drive_cfg.svh"

module drive_encoder_chopper_monitor_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic               clk = 1'b0;
	logic               reset = 1'b1;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0000_0000;
	logic               wr_en = 1'b0;
	logic               rd_en = 1'b0;
	logic [31:0]        rdata;
	logic [15:0]        dc_link_voltage = 16'h0000;
	logic [11:0]        analog_multifunction_input = 12'h000;
	logic [15:0]        winding_temp_measured = 16'h0000;
	logic [15:0]        rotor_resistance_base = 16'h03E8;
	logic signed [15:0] speed_actual = 16'sh0000;
	logic signed [15:0] speed_reference = 16'sh0000;
	logic               drive_release = 1'b0;
	logic               start_cw = 1'b0;
	logic               start_ccw = 1'b0;
	logic               enc_a;
	logic               enc_b;
	logic               run = 1'b0;
	logic               fwd = 1'b1;
	logic               glitch = 1'b0;
	logic               chopper_on;
	logic               fault_switch_off;
	logic               irq;
	logic [15:0]        motor_temp;
	logic [15:0]        rotor_resistance;
	logic [15:0]        fault_code;
	int                 num_errors = 0;
	int                 n_tests = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	// short tick and revolution so the millisecond timeouts fit in a short run
	drive_encoder_chopper_monitor #(.TICK_CYCLES(10), .COUNTS_PER_REV(8), .AIN_W(12)) dut_u (
		.clk, .reset, .addr, .wdata, .wr_en, .rd_en, .rdata, .dc_link_voltage,
		.analog_multifunction_input, .winding_temp_measured, .rotor_resistance_base,
		.speed_actual, .speed_reference, .drive_release, .start_cw, .start_ccw, .enc_a, .enc_b,
		.chopper_on, .motor_temp, .rotor_resistance, .fault_switch_off, .fault_code, .irq
	);

	quad_encoder_model enc_u (.clk, .run, .fwd, .glitch, .enc_a, .enc_b);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		#1;
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
		@(posedge clk) wr_en <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk) begin addr <= a; rd_en <= 1'b1; end
		@(posedge clk) rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic do_reset;
		@(posedge clk) begin
			reset <= 1'b1; dc_link_voltage <= 16'h0000; speed_actual <= 16'sh0000;
			speed_reference <= 16'sh0000; drive_release <= 1'b0; start_cw <= 1'b0;
			start_ccw <= 1'b0; run <= 1'b0; glitch <= 1'b0;
		end
		cyc(5);
		@(posedge clk) reset <= 1'b0;
	endtask

	task automatic expect_fault(input int n, input logic [15:0] code);
		cyc(n);
		chk(fault_code, code);
		chk(fault_switch_off, code != 16'h0000);
	endtask

	task automatic t_regs;
		logic [7:0]  ofs [9] = '{`OFS_CHOP, `OFS_UDMAX, `OFS_MAINS, `OFS_COEF, `OFS_ADJ, `OFS_TO_SIG,
			`OFS_TO_CH, `OFS_TO_DIR, 8'h3C};
		logic [31:0] rv [9] = '{32'h0000_1D4C, 32'h0000_1F40, 32'h0000_1B58, 32'h0000_0F3C,
			32'h0000_0023, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_03E8, 32'h0000_0000};
		logic [31:0] d;
		do_reset;
		chk(motor_temp, 16'h0023);
		for (int i = 0; i < 9; i++) begin
			rd(ofs[i], d);
			chk(d, rv[i]);
		end
		// values above the limits clamp
		wr(`OFS_CHOP, 32'h0000_FFFF);
		rd(`OFS_CHOP, d);
		chk(d, 32'h0000_2710);
		wr(`OFS_COEF, 32'h0000_FFFF);
		rd(`OFS_COEF, d);
		chk(d, 32'h0000_7530);
		wr(`OFS_TO_SIG, 32'h0000_FFFF);
		rd(`OFS_TO_SIG, d);
		chk(d, 32'h0000_FDE8);
	endtask

	task automatic t_chopper;
		do_reset;
		@(posedge clk) dc_link_voltage <= 16'h1D4C;
		cyc(3);
		chk(chopper_on, 1'b0);
		@(posedge clk) dc_link_voltage <= 16'h1D4D;
		cyc(3);
		chk(chopper_on, 1'b1);
		wr(`OFS_CHOP, 32'h0000_1F40);
		@(posedge clk) dc_link_voltage <= 16'h1F41;
		cyc(3);
		chk(chopper_on, 1'b1);
		wr(`OFS_CHOP, 32'h0000_1F41);
		@(posedge clk) dc_link_voltage <= 16'hFFFF;
		cyc(3);
		chk(chopper_on, 1'b0);
	endtask

	// threshold equal to mains peak passes, one below trips
	task automatic t_switch_on;
		logic [31:0] d;
		for (int i = 0; i < 2; i++) begin
			do_reset;
			wr(`OFS_MASK, 32'h0000_0000);
			wr(`OFS_CHOP, i ? 32'h0000_1B57 : 32'h0000_1B58);
			wr(`OFS_CTRL, 32'h0000_0100);
			expect_fault(4, i ? `CODE_F0706 : 16'h0000);
			chk(irq, 1'b0);
		end
		wr(`OFS_MASK, 32'h0000_0001);
		cyc(2);
		chk(irq, 1'b1);
		rd(`OFS_STAT, d);
		chk(d, 32'h0000_0001);
		cyc(2);
		chk(irq, 1'b0);
		wr(`OFS_CTRL, 32'h0000_0200);
		expect_fault(2, 16'h0000);
	endtask

	task automatic arm(input logic [31:0] ctl, input logic [15:0] ts, tc, td, input logic rel);
		do_reset;
		wr(`OFS_TO_SIG, {16'h0000, ts});
		wr(`OFS_TO_CH, {16'h0000, tc});
		wr(`OFS_TO_DIR, {16'h0000, td});
		wr(`OFS_CTRL, ctl);
		@(posedge clk) begin drive_release <= rel; start_cw <= 1'b1; end
	endtask

	// a four cycle gap must restart the timing
	task automatic t_signal;
		logic [31:0] d;
		arm(32'h0000_0120, 16'h0003, 16'h0000, 16'h0000, 1'b1);
		@(posedge clk) speed_reference <= 16'sh0064;
		expect_fault(17, 16'h0000);
		@(posedge clk) speed_reference <= 16'sh0000;
		cyc(3);
		@(posedge clk) speed_reference <= 16'sh0064;
		expect_fault(17, 16'h0000);
		expect_fault(28, `CODE_F1430);
		rd(`OFS_STAT, d);
		chk(d, 32'h0000_0002);
		rd(`OFS_LIVE, d);
		chk(d, 32'h0000_00A9);
	endtask

	// mode off, no release, zero timeout: none may trip
	task automatic t_idle;
		logic [31:0] ctl [3] = '{32'h0000_0100, 32'h0000_0120, 32'h0000_0120};
		logic [15:0] ts [3] = '{16'h0003, 16'h0003, 16'h0000};
		logic        rel [3] = '{1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 3; i++) begin
			arm(ctl[i], ts[i], 16'h0000, 16'h0000, rel[i]);
			@(posedge clk) speed_reference <= 16'sh0064;
			expect_fault(60, 16'h0000);
		end
	endtask

	task automatic t_channel;
		arm(32'h0000_0120, 16'h0000, 16'h0003, 16'h0000, 1'b1);
		@(posedge clk) begin speed_reference <= 16'sh0064; speed_actual <= 16'sh0064; end
		cyc(5);
		@(posedge clk) glitch <= 1'b1;
		@(posedge clk) glitch <= 1'b0;
		expect_fault(17, 16'h0000);
		expect_fault(28, `CODE_F1431);
	endtask

	// forward travel keeps restarting the check; stopping lets it trip
	task automatic t_direction;
		arm(32'h0000_0120, 16'h0000, 16'h0000, 16'h0003, 1'b1);
		@(posedge clk) begin speed_reference <= 16'sh0064; speed_actual <= -16'sh0064; run <= 1'b1; end
		expect_fault(80, 16'h0000);
		@(posedge clk) run <= 1'b0;
		expect_fault(50, `CODE_F1432);
	endtask

	task automatic t_temp;
		logic [11:0] ain [3] = '{12'h000, 12'h800, 12'hFFF};
		logic [15:0] tv [3] = '{16'h0000, 16'h0064, 16'h00C8};
		logic [31:0] d;
		do_reset;
		wr(`OFS_CTRL, 32'h0000_0101);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) analog_multifunction_input <= ain[i];
			cyc(4);
			chk(motor_temp, tv[i]);
		end
		wr(`OFS_CTRL, 32'h0000_0104);
		@(posedge clk) begin drive_release <= 1'b1; start_ccw <= 1'b1; winding_temp_measured <= 16'h0087; end
		cyc(8);
		chk(motor_temp, 16'h0087);
		chk(rotor_resistance, 16'h056E);
		rd(`OFS_TEMP, d);
		chk(d, 32'h056E_0087);
		wr(`OFS_CTRL, 32'h0000_0100);
		cyc(8);
		chk(motor_temp, 16'h0023);
		chk(rotor_resistance, 16'h03E8);
	endtask

	// main sequence
	initial begin
		do_reset;
		t_regs;
		t_chopper;
		t_switch_on;
		t_signal;
		t_idle;
		t_channel;
		t_direction;
		t_temp;
		give_verdict;
	end

	// the whole run needs under a thousand cycles; cut a hang well beyond that
	initial begin
		#500us;
		num_errors++;
		give_verdict;
	end
endmodule

// ---- tb/quad_encoder_model.sv ----
module quad_encoder_model (
	input  wire logic clk,
	input  wire logic run,
	input  wire logic fwd,
	input  wire logic glitch,
	output logic      enc_a,
	output logic      enc_b
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [1:0] pos_q  = 2'h0;
	logic [1:0] div_q  = 2'h0;
	logic       flip_q = 1'b0;

	// one quadrature step every four clocks while the shaft turns; tracks hold when it stops
	always @(posedge clk) begin
		div_q <= run ? div_q + 2'h1 : 2'h0;
		if (run && div_q == 2'h3)
			pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
	end

	// a glitch flips both tracks at once, a jump no real shaft can make
	always @(posedge clk) begin
		if (glitch)
			flip_q <= ~flip_q;
	end

	// gray coding, track a leads track b when turning forward
	assign enc_a = pos_q[0] ^ pos_q[1] ^ flip_q;
	assign enc_b = pos_q[1] ^ flip_q;
endmodule
